// ---- design/step_prog_map.vh ----
/*
  Constants for the stepped program command block: opcodes, limits,
  reset values, text characters and timing.
  Assumes a 40 MHz system clock and inclusion by bare name.
*/
`ifndef STEP_PROG_MAP_VH
`define STEP_PROG_MAP_VH

// ----------------------------------------
// Command opcodes
// ----------------------------------------
`define OP_WRITE_ENTRY 2'h0
`define OP_READ_RUN 2'h1
`define OP_RESTART 2'h2
`define OP_SET_STEPS 2'h3

// ----------------------------------------
// Limits and reset values
// ----------------------------------------
`define TABLE_DEPTH 12'h800
`define STEPS_MIN 12'h001
`define STEPS_RST 12'h001
`define DWELL_MIN_S 9'h001
`define DWELL_MAX_S 9'h12C
`define VOLT_MAX_MV 16'hEA60
`define CURR_MAX_MA 16'h2710

// ----------------------------------------
// Response text
// ----------------------------------------
`define CH_HASH 8'h23
`define CH_NINE 8'h39
`define CH_ZERO 8'h30
`define CH_COMMA 8'h2C
`define CH_SEMI 8'h3B
`define HDR_LAST 4'hA

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ 40000000
`define DWELL_UNIT_S 1
`define SEC_CYCLES (`CLK_HZ * `DWELL_UNIT_S)

`endif

// ---- design/step_program_table_commands.v ----
/*
  Stepped output program: entry writes, run readback as a length-prefixed
  text block, restart, step count, and the step sequencer itself.
  Assumes commands arrive already decoded; voltage in mV, current in mA.
*/
// How it works
// [R1] Step count reads back between 1 and 2048, default 1
// [R2] Entry write stores voltage, current, dwell at given index
// [R3] Host gives write index 0 to 2047
// [R4] Host gives voltage within channel voltage range
// [R5] Host gives current within channel current range
// [R6] Host gives dwell from 1 to 300 seconds
// [R7] Read returns consecutive entries from start index, count long
// [R8] Host gives read start index 0 to 2047
// [R9] Host gives read count 1 to 2048
// [R10] Response begins hash, nine, nine length digits, then payload
// [R11] Entry printed index,volt,curr,dwell then semicolon
// [R12] Restart runs program again from first step
// [R13] Total steps equals step count times cycles, then stop; with cycles_i at 0 the code runs on and never stops
// [R14] Output driven only while program and channel output enabled
// [R15] Parameter changes refused while program enabled
// [R16] Keep-last end state holds final step after completion
// [R17] Out-of-range arguments rejected, table left unchanged
`timescale 1ns/1ps
`include "step_prog_map.vh"
module step_program_table_commands #(
  parameter SEC_CYCLES = `SEC_CYCLES,
  parameter CYC_W = 16
) (
  // Clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  input wire ce_i,
  // Command
  input wire cmd_valid_i,
  input wire [1:0] cmd_op_i,
  input wire [10:0] cmd_idx_i,
  input wire [11:0] cmd_cnt_i,
  input wire [15:0] cmd_volt_i,
  input wire [15:0] cmd_curr_i,
  input wire [8:0] cmd_dwell_i,
  output wire cmd_ready_o,
  output reg cmd_ack_o,
  output reg cmd_err_o,
  output reg [11:0] steps_o,
  // Response bytes
  output reg resp_valid_o,
  output reg [7:0] resp_data_o,
  input wire resp_ready_i,
  // Program control
  input wire prog_en_i,
  input wire chan_on_i,
  input wire [CYC_W-1:0] cycles_i,
  input wire keep_last_i,
  // Stepped output
  output reg out_on_o,
  output reg [15:0] out_volt_o,
  output reg [15:0] out_curr_o,
  output reg [10:0] step_o,
  output reg done_o
);

  localparam S_IDLE = 7'h01;
  localparam S_LRD = 7'h02;
  localparam S_LADD = 7'h04;
  localparam S_HDR = 7'h08;
  localparam S_BRD = 7'h10;
  localparam S_BLD = 7'h20;
  localparam S_EMIT = 7'h40;

  function [2:0] ndig;
    input [15:0] v;
    begin
      if (v >= 16'd10000) ndig = 3'd5;
      else if (v >= 16'd1000) ndig = 3'd4;
      else if (v >= 16'd100) ndig = 3'd3;
      else if (v >= 16'd10) ndig = 3'd2;
      else ndig = 3'd1;
    end
  endfunction

  function [7:0] dchar;
    input [31:0] v;
    input [3:0] p;
    reg [31:0] pw;
    reg [31:0] dg;
    begin
      case (p)
        4'd0: pw = 32'd1;
        4'd1: pw = 32'd10;
        4'd2: pw = 32'd100;
        4'd3: pw = 32'd1000;
        4'd4: pw = 32'd10000;
        4'd5: pw = 32'd100000;
        4'd6: pw = 32'd1000000;
        4'd7: pw = 32'd10000000;
        default: pw = 32'd100000000;
      endcase
      dg = (v / pw) % 32'd10;
      dchar = `CH_ZERO + dg[7:0];
    end
  endfunction

  reg [6:0] st_ff;
  reg [10:0] ptr_ff;
  reg [11:0] cnt_ff;
  reg [10:0] start_ff;
  reg [11:0] total_ff;
  reg [31:0] len_ff;
  reg [3:0] hpos_ff;
  reg [1:0] fld_ff;
  reg [2:0] pos_ff;
  reg sep_ff;
  reg [15:0] ent_ff [0:3];
  wire [51:0] rd_a;
  wire [51:0] rd_b;
  wire [15:0] fv;
  wire [15:0] nfv;
  wire emit_go;
  wire fire;
  wire bad_entry;
  wire bad_run;
  wire [31:0] ent_len;
  reg [7:0] nxt_byte;

  assign cmd_ready_o = st_ff[0] & ~resp_valid_o;
  assign fire = ce_i & cmd_valid_i & cmd_ready_o;
  assign emit_go = ~resp_valid_o | resp_ready_i;
  // [R17] Argument range checks
  assign bad_entry = (cmd_volt_i > `VOLT_MAX_MV) | (cmd_curr_i > `CURR_MAX_MA) |
                     (cmd_dwell_i < `DWELL_MIN_S) | (cmd_dwell_i > `DWELL_MAX_S);
  assign bad_run = (cmd_cnt_i == 12'h000) | (cmd_cnt_i > `TABLE_DEPTH) |
                   ({1'b0, cmd_idx_i} + cmd_cnt_i > `TABLE_DEPTH);
  assign fv = ent_ff[fld_ff];
  assign nfv = ent_ff[fld_ff + 2'd1];
  assign ent_len = {29'd0, ndig({5'd0, rd_b[51:41]})} + {29'd0, ndig(rd_b[40:25])} +
                   {29'd0, ndig(rd_b[24:9])} + {29'd0, ndig({7'd0, rd_b[8:0]})} + 32'd4;

  // ----------------------------------------
  // Table storage
  // ----------------------------------------
  step_table_mem #(.AW(11), .DW(52)) u_mem (
    .clk_sys_i(clk_sys_i),
    .ce_i(ce_i),
    // [R2] Entry write
    .wr_en_i(fire & (cmd_op_i == `OP_WRITE_ENTRY) & ~prog_en_i & ~bad_entry),
    .wr_addr_i(cmd_idx_i),
    .wr_data_i({cmd_idx_i, cmd_volt_i, cmd_curr_i, cmd_dwell_i}),
    .rd_a_addr_i(step_o),
    .rd_a_data_o(rd_a),
    .rd_b_addr_i(ptr_ff),
    .rd_b_data_o(rd_b)
  );

  // ----------------------------------------
  // Command intake and response text
  // ----------------------------------------
  always @* begin
    nxt_byte = `CH_ZERO;
    if (st_ff[3]) begin
      if (hpos_ff == 4'd0) nxt_byte = `CH_HASH;
      else if (hpos_ff == 4'd1) nxt_byte = `CH_NINE;
      else nxt_byte = dchar(len_ff, `HDR_LAST - hpos_ff);
    end else if (sep_ff) begin
      nxt_byte = (fld_ff == 2'd3) ? `CH_SEMI : `CH_COMMA;
    end else begin
      nxt_byte = dchar({16'd0, fv}, {1'b0, pos_ff});
    end
  end

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      st_ff <= S_IDLE;
      ptr_ff <= 11'h000;
      cnt_ff <= 12'h000;
      start_ff <= 11'h000;
      total_ff <= 12'h000;
      len_ff <= 32'h0;
      hpos_ff <= 4'h0;
      fld_ff <= 2'h0;
      pos_ff <= 3'h0;
      sep_ff <= 1'b0;
      steps_o <= `STEPS_RST;
      cmd_ack_o <= 1'b0;
      cmd_err_o <= 1'b0;
      resp_valid_o <= 1'b0;
      resp_data_o <= 8'h00;
    end else if (ce_i) begin
      cmd_ack_o <= 1'b0;
      cmd_err_o <= 1'b0;
      if (resp_valid_o & resp_ready_i) resp_valid_o <= 1'b0;
      case (st_ff)
        S_IDLE: begin
          if (fire) begin
            cmd_ack_o <= 1'b1;
            case (cmd_op_i)
              // [R15] Refuse edits while enabled
              `OP_WRITE_ENTRY: cmd_err_o <= prog_en_i | bad_entry;
              `OP_SET_STEPS: begin
                // [R1] Step count kept in range
                if (prog_en_i | (cmd_cnt_i < `STEPS_MIN) | (cmd_cnt_i > `TABLE_DEPTH))
                  cmd_err_o <= 1'b1;
                else steps_o <= cmd_cnt_i;
              end
              `OP_READ_RUN: begin
                if (bad_run) cmd_err_o <= 1'b1;
                else begin
                  ptr_ff <= cmd_idx_i;
                  start_ff <= cmd_idx_i;
                  cnt_ff <= cmd_cnt_i;
                  total_ff <= cmd_cnt_i;
                  len_ff <= 32'h0;
                  st_ff <= S_LRD;
                end
              end
              default: ;
            endcase
          end
        end
        S_LRD: st_ff <= S_LADD;
        // [R10] Length pass before header
        S_LADD: begin
          len_ff <= len_ff + ent_len;
          ptr_ff <= ptr_ff + 11'd1;
          cnt_ff <= cnt_ff - 12'd1;
          hpos_ff <= 4'h0;
          st_ff <= (cnt_ff == 12'd1) ? S_HDR : S_LRD;
        end
        S_HDR: begin
          if (emit_go) begin
            resp_valid_o <= 1'b1;
            resp_data_o <= nxt_byte;
            hpos_ff <= hpos_ff + 4'd1;
            if (hpos_ff == `HDR_LAST) begin
              ptr_ff <= start_ff;
              cnt_ff <= total_ff;
              st_ff <= S_BRD;
            end
          end
        end
        S_BRD: st_ff <= S_BLD;
        S_BLD: begin
          ent_ff[0] <= {5'd0, rd_b[51:41]};
          ent_ff[1] <= rd_b[40:25];
          ent_ff[2] <= rd_b[24:9];
          ent_ff[3] <= {7'd0, rd_b[8:0]};
          fld_ff <= 2'd0;
          sep_ff <= 1'b0;
          pos_ff <= ndig({5'd0, rd_b[51:41]}) - 3'd1;
          st_ff <= S_EMIT;
        end
        // [R11] Fields, commas, semicolon
        S_EMIT: begin
          if (emit_go) begin
            resp_valid_o <= 1'b1;
            resp_data_o <= nxt_byte;
            if (!sep_ff) begin
              if (pos_ff == 3'd0) sep_ff <= 1'b1;
              else pos_ff <= pos_ff - 3'd1;
            end else if (fld_ff != 2'd3) begin
              fld_ff <= fld_ff + 2'd1;
              pos_ff <= ndig(nfv) - 3'd1;
              sep_ff <= 1'b0;
            end else begin
              // [R7] Next consecutive entry
              ptr_ff <= ptr_ff + 11'd1;
              cnt_ff <= cnt_ff - 12'd1;
              st_ff <= (cnt_ff == 12'd1) ? S_IDLE : S_BRD;
            end
          end
        end
        default: st_ff <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Step sequencer
  // ----------------------------------------
  reg run_ff;
  reg [1:0] load_ff;
  reg [CYC_W-1:0] cyc_ff;
  reg [31:0] tick_ff;
  reg [8:0] sec_ff;
  wire live;
  wire restart;
  wire last_step;

  assign live = prog_en_i & chan_on_i;
  assign restart = fire & (cmd_op_i == `OP_RESTART);
  assign last_step = (step_o == steps_o[10:0] - 11'd1);

  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      run_ff <= 1'b0;
      load_ff <= 2'b00;
      cyc_ff <= {CYC_W{1'b0}};
      tick_ff <= 32'h0;
      sec_ff <= 9'h000;
      step_o <= 11'h000;
      done_o <= 1'b0;
      out_on_o <= 1'b0;
      out_volt_o <= 16'h0000;
      out_curr_o <= 16'h0000;
    end else if (ce_i) begin
      // [R14] Run only with both enables
      if (!live) begin
        run_ff <= 1'b0;
        out_on_o <= 1'b0;
        if (!prog_en_i) done_o <= 1'b0;
      // [R12] Restart from first step
      end else if (restart | (!run_ff & !done_o)) begin
        run_ff <= 1'b1;
        done_o <= 1'b0;
        step_o <= 11'h000;
        cyc_ff <= {CYC_W{1'b0}};
        load_ff <= 2'b10;
      // Wait for table read of new step
      end else if (run_ff & (load_ff == 2'b10)) begin
        load_ff <= 2'b01;
      end else if (run_ff & (load_ff == 2'b01)) begin
        load_ff <= 2'b00;
        out_volt_o <= rd_a[40:25];
        out_curr_o <= rd_a[24:9];
        out_on_o <= 1'b1;
        sec_ff <= rd_a[8:0];
        tick_ff <= 32'h0;
      end else if (run_ff) begin
        if (tick_ff == SEC_CYCLES - 1) begin
          tick_ff <= 32'h0;
          sec_ff <= sec_ff - 9'd1;
        end else begin
          tick_ff <= tick_ff + 32'd1;
        end
        if ((sec_ff <= 9'd1) & (tick_ff == SEC_CYCLES - 1)) begin
          // [R13] Stop after count times cycles_i, never when cycles_i is 0
          if (last_step & (cycles_i != {CYC_W{1'b0}}) &
              (cyc_ff == cycles_i - {{(CYC_W-1){1'b0}}, 1'b1})) begin
            run_ff <= 1'b0;
            done_o <= 1'b1;
            // [R16] Hold last step or switch off
            out_on_o <= keep_last_i;
          end else begin
            step_o <= last_step ? 11'h000 : step_o + 11'd1;
            if (last_step) cyc_ff <= cyc_ff + {{(CYC_W-1){1'b0}}, 1'b1};
            load_ff <= 2'b10;
          end
        end
      end
    end
  end

endmodule

// ---- design/step_table_mem.v ----
/*
  Program table storage: one write port, two registered read ports.
  Assumes a single clock; all ports freeze while ce_i is low.
*/
`timescale 1ns/1ps
module step_table_mem #(
  parameter AW = 11,
  parameter DW = 52
) (
  // Clock
  input wire clk_sys_i,
  input wire ce_i,
  // Write port
  input wire wr_en_i,
  input wire [AW-1:0] wr_addr_i,
  input wire [DW-1:0] wr_data_i,
  // Read ports
  input wire [AW-1:0] rd_a_addr_i,
  output reg [DW-1:0] rd_a_data_o,
  input wire [AW-1:0] rd_b_addr_i,
  output reg [DW-1:0] rd_b_data_o
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk_sys_i) begin
    if (ce_i) begin
      if (wr_en_i) begin
        mem[wr_addr_i] <= wr_data_i;
      end
      rd_a_data_o <= mem[rd_a_addr_i];
      rd_b_data_o <= mem[rd_b_addr_i];
    end
  end

endmodule

// ---- tb/step_host_sink.sv ----
/*
  Remote host response sink: collects response bytes in order.
  Assumes a valid/ready byte handshake on clk_sys_i.
*/
`timescale 1ns/1ps
module step_host_sink (
  // Clock
  input wire clk_sys_i,
  // Response bytes
  input wire resp_valid_i,
  input wire [7:0] resp_data_i,
  output reg resp_ready_o,
  // Pace
  input wire slow_i
);
  reg [7:0] got[$];
  reg phase_ff = 1'b0;
  initial resp_ready_o = 1'b0;
  // Byte taken on rising clock edge while ready is high
  always @(posedge clk_sys_i) begin
    if (resp_valid_i === 1'b1 && resp_ready_o) got.push_back(resp_data_i);
  end
  // Prompt, or ready every other cycle
  always @(negedge clk_sys_i) begin
    phase_ff <= ~phase_ff;
    resp_ready_o <= !slow_i || phase_ff;
  end
endmodule

// ---- tb/step_program_table_commands_props.sv ----
/*
  Checker for the stepped program command block, bound to its top ports.
  Assumes one clock domain with synchronous active-high reset.
*/
`timescale 1ns/1ps
module step_program_table_commands_props (
  // Clock and reset
  input wire clk_sys_i,
  input wire reset_i,
  input wire ce_i,
  // Command
  input wire cmd_valid_i,
  input wire [1:0] cmd_op_i,
  input wire [10:0] cmd_idx_i,
  input wire [11:0] cmd_cnt_i,
  input wire [15:0] cmd_volt_i,
  input wire [15:0] cmd_curr_i,
  input wire [8:0] cmd_dwell_i,
  input wire cmd_ready_o,
  input wire cmd_ack_o,
  input wire cmd_err_o,
  input wire [11:0] steps_o,
  // Response and program
  input wire resp_valid_o,
  input wire [7:0] resp_data_o,
  input wire resp_ready_i,
  input wire prog_en_i,
  input wire chan_on_i,
  input wire keep_last_i,
  input wire out_on_o,
  input wire done_o
);
  wire taken = ce_i && cmd_valid_i && cmd_ready_o;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_ack_follows_take: assert property (taken |=> cmd_ack_o)
    else $error("ack missing after taken command");
  a_err_with_ack: assert property (cmd_err_o |-> cmd_ack_o)
    else $error("refusal without ack");
  a_steps_in_range: assert property (steps_o >= 12'h001 && steps_o <= 12'h800)
    else $error("step count out of range");
  a_steps_set_value: assert property (
    taken && cmd_op_i == 2'h3 && !prog_en_i && cmd_cnt_i >= 12'h001 && cmd_cnt_i <= 12'h800
    |=> !cmd_err_o && steps_o == $past(cmd_cnt_i))
    else $error("step count not stored");
  a_locked_while_on: assert property (
    taken && cmd_op_i != 2'h1 && cmd_op_i != 2'h2 && prog_en_i |=> cmd_err_o)
    else $error("change accepted while enabled");
  a_write_bad_args: assert property (
    taken && cmd_op_i == 2'h0 && (cmd_dwell_i == 9'h000
    || cmd_dwell_i > 9'h12C || cmd_volt_i > 16'hEA60 || cmd_curr_i > 16'h2710)
    |=> cmd_err_o)
    else $error("bad write accepted");
  a_read_bad_args: assert property (
    taken && cmd_op_i == 2'h1 && (cmd_cnt_i == 12'h000
    || ({1'b0, cmd_idx_i} + cmd_cnt_i) > 12'h800) |=> cmd_err_o)
    else $error("bad read accepted");
  a_resp_byte_hold: assert property (
    resp_valid_o && !resp_ready_i && ce_i |=> resp_valid_o && $stable(resp_data_o))
    else $error("response byte dropped");
  a_out_needs_enable: assert property ((!prog_en_i || !chan_on_i) [*2] |-> !out_on_o)
    else $error("output on while disabled");
  a_end_state_off: assert property (done_o && !keep_last_i |-> !out_on_o)
    else $error("output left on after end");
endmodule
bind step_program_table_commands step_program_table_commands_props props_u (
  .clk_sys_i, .reset_i, .ce_i, .cmd_valid_i, .cmd_op_i, .cmd_idx_i, .cmd_cnt_i,
  .cmd_volt_i, .cmd_curr_i, .cmd_dwell_i, .cmd_ready_o, .cmd_ack_o, .cmd_err_o,
  .steps_o, .resp_valid_o, .resp_data_o, .resp_ready_i, .prog_en_i, .chan_on_i,
  .keep_last_i, .out_on_o, .done_o);

// ---- tb/step_program_table_commands_test.sv ----
/*
  Testbench for the stepped program command block.
  Assumes a 40 MHz clock and a shortened second of four cycles.
*/
`timescale 1ns/1ps
`include "step_prog_map.vh"
module step_program_table_commands_test;
  reg clk_sys_i = 1'b0;
  reg reset_i = 1'b1;
  reg cmd_valid_i = 1'b0;
  reg [1:0] cmd_op_i = 2'h0;
  reg [10:0] cmd_idx_i = 11'h000;
  reg [11:0] cmd_cnt_i = 12'h000;
  reg [15:0] cmd_volt_i = 16'h0000;
  reg [15:0] cmd_curr_i = 16'h0000;
  reg [8:0] cmd_dwell_i = 9'h000;
  reg prog_en_i = 1'b0;
  reg chan_on_i = 1'b0;
  reg [15:0] cycles_i = 16'h0001;
  reg keep_last_i = 1'b1;
  reg slow = 1'b0;
  reg ce_i = 1'b1;
  wire cmd_ready_o, cmd_ack_o, cmd_err_o, resp_valid_o, resp_ready_i, out_on_o, done_o;
  wire [11:0] steps_o;
  wire [7:0] resp_data_o;
  wire [15:0] out_volt_o, out_curr_o;
  wire [10:0] step_o;
  integer failures = 0;
  integer samples_checked = 0;
  integer cycle_count = 0;
  always #12.5 clk_sys_i = ~clk_sys_i;
  step_program_table_commands #(.SEC_CYCLES(4), .CYC_W(16)) dut_u (.clk_sys_i, .reset_i,
    .ce_i, .cmd_valid_i, .cmd_op_i, .cmd_idx_i, .cmd_cnt_i, .cmd_volt_i, .cmd_curr_i,
    .cmd_dwell_i, .cmd_ready_o, .cmd_ack_o, .cmd_err_o, .steps_o, .resp_valid_o,
    .resp_data_o, .resp_ready_i, .prog_en_i, .chan_on_i, .cycles_i, .keep_last_i,
    .out_on_o, .out_volt_o, .out_curr_o, .step_o, .done_o);
  step_host_sink host_u (.clk_sys_i, .resp_valid_i(resp_valid_o),
    .resp_data_i(resp_data_o), .resp_ready_o(resp_ready_i), .slow_i(slow));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task conclude;
    begin
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
        $display("No errors found");
      end else begin
        $display("Errors were found");
      end
      $finish;
    end
  endtask
  always @(posedge clk_sys_i) begin
    cycle_count = cycle_count + 1;
    if (cycle_count == 20000) begin
      failures = failures + 1;
      conclude;
    end
  end
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("wrong value %s expected %0h seen %0h", what, exp, got);
      end
    end
  endtask
  task cmd(input [1:0] op, input [10:0] idx, input [11:0] cnt, input [15:0] v,
    input [15:0] c, input [8:0] d, input logic bad);
    begin
      @(negedge clk_sys_i);
      {cmd_op_i, cmd_idx_i, cmd_cnt_i} = {op, idx, cnt};
      {cmd_volt_i, cmd_curr_i, cmd_dwell_i} = {v, c, d};
      cmd_valid_i = 1'b1;
      while (cmd_ready_o !== 1'b1) @(negedge clk_sys_i);
      @(negedge clk_sys_i);
      cmd_valid_i = 1'b0;
      chk("cmd_ack_o", 1, cmd_ack_o);
      chk("cmd_err_o", bad, cmd_err_o);
    end
  endtask
  function string ent(input integer i, input integer v, input integer c, input integer d);
    ent = $sformatf("%0d,%0d,%0d,%0d;", i, v, c, d);
  endfunction
  task rd(input [10:0] idx, input [11:0] cnt, input string body);
    string s;
    integer i;
    begin
      host_u.got.delete();
      s = {$sformatf("#9%09d", body.len()), body};
      cmd(2'h1, idx, cnt, 16'h0000, 16'h0000, 9'h000, 1'b0);
      while (host_u.got.size() < s.len()) @(negedge clk_sys_i);
      repeat (20) @(negedge clk_sys_i);
      chk("resp_len", s.len(), host_u.got.size());
      for (i = 0; i < s.len(); i++) chk("resp_data_o", s[i], host_u.got[i]);
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_table;
    begin
      slow = 1'b1;
      cmd(2'h0, 11'h001, 12'h000, 16'h1F40, 16'h03E8, 9'h00A, 1'b0);
      cmd(2'h0, 11'h002, 12'h000, 16'h1770, 16'h03E8, 9'h00A, 1'b0);
      cmd(2'h0, 11'h7FF, 12'h000, `VOLT_MAX_MV, `CURR_MAX_MA, 9'h12C, 1'b0);
      rd(11'h001, 12'h002, {ent(1, 8000, 1000, 10), ent(2, 6000, 1000, 10)});
      rd(11'h7FF, 12'h001, ent(2047, 60000, 10000, 300));
      $display("test table done");
    end
  endtask
  task t_refuse;
    begin
      cmd(2'h0, 11'h002, 12'h000, 16'h0001, 16'h0001, 9'h000, 1'b1);
      cmd(2'h0, 11'h002, 12'h000, 16'h0001, 16'h0001, 9'h12D, 1'b1);
      cmd(2'h0, 11'h002, 12'h000, 16'hEA61, 16'h0001, 9'h005, 1'b1);
      cmd(2'h0, 11'h002, 12'h000, 16'h0001, 16'h2711, 9'h005, 1'b1);
      cmd(2'h1, 11'h000, 12'h000, 16'h0000, 16'h0000, 9'h000, 1'b1);
      cmd(2'h1, 11'h001, 12'h800, 16'h0000, 16'h0000, 9'h000, 1'b1);
      cmd(2'h3, 11'h000, 12'h000, 16'h0000, 16'h0000, 9'h000, 1'b1);
      cmd(2'h3, 11'h000, 12'h801, 16'h0000, 16'h0000, 9'h000, 1'b1);
      cmd(2'h3, 11'h000, 12'h800, 16'h0000, 16'h0000, 9'h000, 1'b0);
      chk("steps_o", 12'h800, steps_o);
      rd(11'h002, 12'h001, ent(2, 6000, 1000, 10));
      slow = 1'b0;
      $display("test refuse done");
    end
  endtask
  task t_run;
    begin
      cmd(2'h0, 11'h000, 12'h000, 16'h03E8, 16'h0064, 9'h005, 1'b0);
      cmd(2'h3, 11'h000, 12'h002, 16'h0000, 16'h0000, 9'h000, 1'b0);
      prog_en_i = 1'b1;
      chan_on_i = 1'b1;
      while (out_on_o !== 1'b1) @(negedge clk_sys_i);
      chk("out_volt_o", 16'h03E8, out_volt_o);
      chk("out_curr_o", 16'h0064, out_curr_o);
      chk("step_o", 11'h000, step_o);
      ce_i = 1'b0;
      repeat (40) @(negedge clk_sys_i);
      chk("step_o", 11'h000, step_o);
      chk("out_on_o", 1, out_on_o);
      ce_i = 1'b1;
      cmd(2'h3, 11'h000, 12'h005, 16'h0000, 16'h0000, 9'h000, 1'b1);
      chk("steps_o", 12'h002, steps_o);
      while (done_o !== 1'b1) @(negedge clk_sys_i);
      chk("step_o", 11'h001, step_o);
      chk("out_volt_o", 16'h1F40, out_volt_o);
      chk("out_curr_o", 16'h03E8, out_curr_o);
      chk("out_on_o", 1, out_on_o);
      cmd(2'h2, 11'h000, 12'h000, 16'h0000, 16'h0000, 9'h000, 1'b0);
      repeat (4) @(negedge clk_sys_i);
      chk("done_o", 0, done_o);
      chk("step_o", 11'h000, step_o);
      chk("out_volt_o", 16'h03E8, out_volt_o);
      chan_on_i = 1'b0;
      repeat (3) @(negedge clk_sys_i);
      chk("out_on_o", 0, out_on_o);
      keep_last_i = 1'b0;
      chan_on_i = 1'b1;
      while (done_o !== 1'b1) @(negedge clk_sys_i);
      chk("out_on_o", 0, out_on_o);
      prog_en_i = 1'b0;
      $display("test run done");
    end
  endtask
  initial begin
    repeat (4) @(negedge clk_sys_i);
    reset_i = 1'b0;
    chk("steps_o", 12'h001, steps_o);
    chk("cmd_ready_o", 1, cmd_ready_o);
    t_table;
    t_refuse;
    t_run;
    conclude;
  end
endmodule
